// ===== verilog/tmc_core_defines.vh
`ifndef TMC_CORE_DEFINES_VH
`define TMC_CORE_DEFINES_VH

// ==========================================================
// Phases of one instruction cycle
`define TMC_PH_ONE 2'h0
`define TMC_PH_TWO 2'h1
`define TMC_PH_THREE 2'h2
`define TMC_PH_FOUR 2'h3

// ==========================================================
// Data register space (5-bit file address)
`define TMC_F_INDIRECT 5'h00
`define TMC_F_PCL 5'h02
`define TMC_F_STATUS 5'h03
`define TMC_F_FSR 5'h04
`define TMC_F_PORT 5'h06
`define TMC_F_GPR_BASE 5'h08

// Status flag positions
`define TMC_ST_C 0
`define TMC_ST_DC 1
`define TMC_ST_Z 2

// Fixed instruction words
`define TMC_INSN_NOP 12'h000
`define TMC_INSN_SLEEP 12'h003

// ==========================================================
// ALU operation codes (match the byte-op field)
`define TMC_OP_PASSA 4'h0
`define TMC_OP_CLR 4'h1
`define TMC_OP_SUB 4'h2
`define TMC_OP_DEC 4'h3
`define TMC_OP_IOR 4'h4
`define TMC_OP_AND 4'h5
`define TMC_OP_XOR 4'h6
`define TMC_OP_ADD 4'h7
`define TMC_OP_PASSB 4'h8
`define TMC_OP_COM 4'h9
`define TMC_OP_INC 4'ha
`define TMC_OP_DECSZ 4'hb
`define TMC_OP_RR 4'hc
`define TMC_OP_RL 4'hd
`define TMC_OP_SWAP 4'he
`define TMC_OP_INCSZ 4'hf

// ==========================================================
// APB register byte addresses
`define TMC_A_CTRL 12'h000
`define TMC_A_CORE 12'h004
`define TMC_A_PORT 12'h008

// Control register bit positions and reset value
`define TMC_CT_XRST 0
`define TMC_CT_PU0 1
`define TMC_CT_PU1 2
`define TMC_CT_PU3 3
`define TMC_CT_WK0 4
`define TMC_CT_WK1 5
`define TMC_CT_WK3 6
`define TMC_CT_DIR0 7
`define TMC_CT_DIR1 8
`define TMC_CT_RESET 9'h000

`endif

// ===== verilog/tmc_alu.v
`include "tmc_core_defines.vh"

// ==========================================================
// 8-bit two's-complement ALU, purely combinational
module tmc_alu (
    op,
    a,
    b,
    cin,
    y,
    c,
    dc
);
    input wire [3:0] op;
    input wire [7:0] a;     // W or literal or bit mask
    input wire [7:0] b;     // File operand or W
    input wire cin;         // Carry in for rotates
    output reg [7:0] y;
    output reg c;
    output reg dc;

    reg [8:0] sum; // Full-width sum, top bit is carry
    reg [4:0] nib; // Low nibble sum, top bit is digit carry

    // Operation select; sub is b plus inverted a plus one
    always @* begin
        sum = 9'h000;
        nib = 5'h00;
        y = b;
        c = cin;
        dc = 1'b0;
        case (op)
            `TMC_OP_PASSA: y = a;
            `TMC_OP_CLR: y = 8'h00;
            `TMC_OP_SUB: begin
                // Carry out of b + ~a + 1 is the inverted borrow [RULE13] [RULE8]
                sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
                nib = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
                y = sum[7:0];
                c = sum[8];
                dc = nib[4];
            end
            `TMC_OP_ADD: begin
                sum = {1'b0, b} + {1'b0, a}; // [RULE7]
                nib = {1'b0, b[3:0]} + {1'b0, a[3:0]};
                y = sum[7:0];
                c = sum[8];
                dc = nib[4];
            end
            `TMC_OP_DEC, `TMC_OP_DECSZ: y = b - 8'h01;
            `TMC_OP_INC, `TMC_OP_INCSZ: y = b + 8'h01;
            `TMC_OP_IOR: y = a | b;
            `TMC_OP_AND: y = a & b;
            `TMC_OP_XOR: y = a ^ b;
            `TMC_OP_PASSB: y = b;
            `TMC_OP_COM: y = ~b;
            `TMC_OP_RR: begin
                // Rotate through carry
                y = {cin, b[7:1]};
                c = b[0];
            end
            `TMC_OP_RL: begin
                y = {b[6:0], cin};
                c = b[7];
            end
            `TMC_OP_SWAP: y = {b[3:0], b[7:4]};
            default: y = b;
        endcase
    end
endmodule // tmc_alu

// ===== verilog/tmc_core_top.v
// How it works
// [RULE1] Program fetch bus separate from data file
// [RULE2] Each instruction is one 12-bit word
// [RULE3] 12-bit fetch bus, one word per cycle
// [RULE4] Fetch overlaps execute; single-cycle instructions
// [RULE5] Program 256/512 words, data 16/24 bytes
// [RULE6] Special registers and PC mapped in file space
// [RULE7] 8-bit ALU: add, subtract, shift, logic
// [RULE8] Arithmetic in two's complement
// [RULE9] Two operands: W and file or literal
// [RULE10] Single operand: W or file register
// [RULE11] W has no file address
// [RULE12] ALU updates carry, half carry, zero
// [RULE13] Subtract flags are inverted borrows
// [RULE14] Reset pin mode: low resets, pull-up on
// [RULE15] Pins 0,1 bidirectional, pull-up and wake
// [RULE16] Pin 3 input only, pull-up and wake
// [RULE17] Four phases; PC on one, latch on four
// [RULE18] PC-changing instructions take two cycles
// [RULE19] Operand read phase two, write phase four
// [RULE20] Zero flag set on all-zero result
//
// Local design decisions: the register offsets and register access over APB.
`include "tmc_core_defines.vh"

module tmc_core_top #(
    parameter PC_W = 9,        // Program counter width, at most 9
    parameter DATA_WORDS = 24  // General purpose bytes, 16 or 24
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg [PC_W-1:0] prog_addr_q,
    input wire [11:0] prog_data,
    input wire port_pin_0_in,
    output reg port_pin_0_out,
    output reg port_pin_0_oe,
    input wire port_pin_1_in,
    output reg port_pin_1_out,
    output reg port_pin_1_oe,
    input wire port_pin_3_input,
    input wire external_reset_pin,
    output reg [2:0] pullup_en_q,
    output reg core_asleep_q
);

    // ==========================================================
    // Core state
    reg [1:0] phase_q;              // Current phase of the cycle
    reg [PC_W-1:0] pc_q;            // Program counter
    reg [11:0] ir_q;                // Instruction register
    reg [7:0] w_q;                  // Working register, no file address
    reg [7:0] fsr_q;                // Indirect pointer
    reg [2:0] flags_q;              // Carry, half carry, zero
    reg [7:0] opnd_q;               // File operand captured in phase two
    reg [7:0] gpr_q [0:DATA_WORDS-1];
    reg [8:0] ctrl_q;               // Software control bits
    reg [2:0] pin_prev_q;           // Pin levels one cycle ago
    integer i;

    // ==========================================================
    // Decode outputs
    reg [3:0] alu_op;
    reg [7:0] alu_a;
    reg [7:0] alu_b;
    reg to_w;       // Result goes to W
    reg to_f;       // Result goes to file register
    reg upd_z;
    reg upd_c;
    reg upd_dc;
    reg skip;       // Conditional skip taken
    reg jump;       // Absolute branch
    reg go_sleep;
    reg [7:0] bit_mask;
    reg [7:0] file_rd;
    wire [7:0] alu_y;
    wire alu_c;
    wire alu_dc;
    wire [4:0] fa;
    wire [4:0] ea;
    wire core_hold;
    wire [2:0] pins_now;
    wire [2:0] wake_en;
    wire wake;
    wire apb_acc;

    // Direct address, or pointer when the indirect slot is named
    function [4:0] eff_addr;
        input [4:0] f;
        input [7:0] ptr;
        begin
            eff_addr = (f == `TMC_F_INDIRECT) ? ptr[4:0] : f; // [RULE6]
        end
    endfunction

    assign fa = ir_q[4:0];
    assign ea = eff_addr(fa, fsr_q);

    // Pin in reset mode and low holds the core in reset
    assign core_hold = ctrl_q[`TMC_CT_XRST] & ~external_reset_pin; // [RULE14]

    // Pin change wake; pin 3 cannot wake while used as reset
    assign pins_now = {port_pin_3_input, port_pin_1_in, port_pin_0_in};
    assign wake_en = {ctrl_q[`TMC_CT_WK3] & ~ctrl_q[`TMC_CT_XRST],
                      ctrl_q[`TMC_CT_WK1], ctrl_q[`TMC_CT_WK0]};
    assign wake = |((pins_now ^ pin_prev_q) & wake_en); // [RULE15] [RULE16]

    // ==========================================================
    // Operand read mux over the data register space
    always @* begin
        file_rd = 8'h00;
        case (ea)
            `TMC_F_PCL: file_rd = pc_q[7:0]; // [RULE6]
            `TMC_F_STATUS: file_rd = {5'h00, flags_q};
            `TMC_F_FSR: file_rd = fsr_q;
            `TMC_F_PORT: file_rd = {4'h0, pins_now[2], 1'b0, pins_now[1:0]};
            default: begin
                // Unimplemented locations read zero
                if (ea >= `TMC_F_GPR_BASE && (ea - `TMC_F_GPR_BASE) < DATA_WORDS)
                    file_rd = gpr_q[ea - `TMC_F_GPR_BASE];
            end
        endcase
    end

    // ==========================================================
    // Instruction decode from the single 12-bit word
    always @* begin
        bit_mask = 8'h01 << ir_q[7:5];
        alu_op = `TMC_OP_PASSB;
        alu_a = w_q;          // W is the first source [RULE9]
        alu_b = opnd_q;
        to_w = 1'b0;
        to_f = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        skip = 1'b0;
        jump = 1'b0;
        go_sleep = 1'b0;
        casez (ir_q) // [RULE2]
            `TMC_INSN_SLEEP: go_sleep = 1'b1;
            12'b0000_001?_????: begin
                // Copy W to file
                alu_op = `TMC_OP_PASSA;
                to_f = 1'b1;
            end
            12'b0000_01??_????: begin
                // Clear W or file
                alu_op = `TMC_OP_CLR;
                to_f = ir_q[5];
                to_w = ~ir_q[5];
                upd_z = 1'b1;
            end
            12'b0000_00??_????: begin
                // Other control words act as no-op
                alu_op = `TMC_OP_PASSB;
            end
            12'b00??_????_????: begin
                // Byte ops on W and file; bit 5 picks destination [RULE10]
                alu_op = ir_q[9:6];
                to_f = ir_q[5];
                to_w = ~ir_q[5];
                upd_z = (ir_q[9:6] <= `TMC_OP_INC); // [RULE12]
                upd_c = (ir_q[9:6] == `TMC_OP_SUB) || (ir_q[9:6] == `TMC_OP_ADD) ||
                        (ir_q[9:6] == `TMC_OP_RR) || (ir_q[9:6] == `TMC_OP_RL);
                upd_dc = (ir_q[9:6] == `TMC_OP_SUB) || (ir_q[9:6] == `TMC_OP_ADD);
                skip = ((ir_q[9:6] == `TMC_OP_DECSZ) || (ir_q[9:6] == `TMC_OP_INCSZ))
                       && (alu_y == 8'h00);
            end
            12'b0100_????_????: begin
                // Clear one bit
                alu_op = `TMC_OP_AND;
                alu_a = ~bit_mask;
                to_f = 1'b1;
            end
            12'b0101_????_????: begin
                // Set one bit
                alu_op = `TMC_OP_IOR;
                alu_a = bit_mask;
                to_f = 1'b1;
            end
            12'b0110_????_????: skip = ((opnd_q & bit_mask) == 8'h00);
            12'b0111_????_????: skip = ((opnd_q & bit_mask) != 8'h00);
            12'b101?_????_????: jump = 1'b1;
            12'b11??_????_????: begin
                // Literal ops: constant from the word with W [RULE9]
                alu_a = ir_q[7:0];
                alu_b = w_q;
                to_w = 1'b1;
                upd_z = (ir_q[9:8] != 2'h0);
                case (ir_q[9:8])
                    2'h0: alu_op = `TMC_OP_PASSA;
                    2'h1: alu_op = `TMC_OP_IOR;
                    2'h2: alu_op = `TMC_OP_AND;
                    default: alu_op = `TMC_OP_XOR;
                endcase
            end
            default: alu_op = `TMC_OP_PASSB; // Subroutine words unsupported
        endcase
    end

    // ==========================================================
    // Arithmetic unit
    tmc_alu u_alu (
        .op(alu_op),
        .a(alu_a),
        .b(alu_b),
        .cin(flags_q[`TMC_ST_C]),
        .y(alu_y),
        .c(alu_c),
        .dc(alu_dc)
    );

    // ==========================================================
    // Phase sequencer, fetch and execute pipeline
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= `TMC_PH_ONE;
            pc_q <= {PC_W{1'b0}};
            prog_addr_q <= {PC_W{1'b0}};
            ir_q <= `TMC_INSN_NOP;
            w_q <= 8'h00;
            fsr_q <= 8'h00;
            flags_q <= 3'h0;
            opnd_q <= 8'h00;
            port_pin_0_out <= 1'b0;
            port_pin_1_out <= 1'b0;
            core_asleep_q <= 1'b0;
            pin_prev_q <= 3'h0;
            for (i = 0; i < DATA_WORDS; i = i + 1)
                gpr_q[i] <= 8'h00;
        end else if (core_hold) begin
            // Reset pin low: restart from the reset vector [RULE14]
            phase_q <= `TMC_PH_ONE;
            pc_q <= {PC_W{1'b0}};
            prog_addr_q <= {PC_W{1'b0}};
            ir_q <= `TMC_INSN_NOP;
            core_asleep_q <= 1'b0;
            pin_prev_q <= pins_now;
        end else begin
            pin_prev_q <= pins_now;
            if (core_asleep_q) begin
                // Stalled until an enabled pin changes
                if (wake)
                    core_asleep_q <= 1'b0;
            end else begin
                phase_q <= phase_q + 2'h1; // [RULE17]
                case (phase_q)
                    `TMC_PH_ONE: begin
                        // Address goes out, counter advances [RULE17] [RULE1]
                        prog_addr_q <= pc_q; // [RULE3]
                        pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
                    end
                    `TMC_PH_TWO: begin
                        opnd_q <= file_rd; // [RULE19]
                    end
                    `TMC_PH_FOUR: begin
                        // Write-back of the executing word [RULE19] [RULE4]
                        if (to_w)
                            w_q <= alu_y; // [RULE11]
                        if (upd_z)
                            flags_q[`TMC_ST_Z] <= (alu_y == 8'h00); // [RULE20] [RULE12]
                        if (upd_c)
                            flags_q[`TMC_ST_C] <= alu_c; // [RULE13]
                        if (upd_dc)
                            flags_q[`TMC_ST_DC] <= alu_dc; // [RULE13]
                        if (to_f) begin
                            case (ea)
                                `TMC_F_PCL: pc_q <= {{(PC_W-8){1'b0}}, alu_y}; // [RULE6]
                                `TMC_F_STATUS: flags_q <= alu_y[2:0];
                                `TMC_F_FSR: fsr_q <= alu_y;
                                `TMC_F_PORT: begin
                                    port_pin_0_out <= alu_y[0];
                                    port_pin_1_out <= alu_y[1];
                                end
                                default: begin
                                    if (ea >= `TMC_F_GPR_BASE &&
                                        (ea - `TMC_F_GPR_BASE) < DATA_WORDS)
                                        gpr_q[ea - `TMC_F_GPR_BASE] <= alu_y; // [RULE5]
                                end
                            endcase
                        end
                        if (jump)
                            pc_q <= ir_q[PC_W-1:0];
                        // Discard the fetched word when flow changes [RULE18]
                        if (jump || skip || (to_f && ea == `TMC_F_PCL))
                            ir_q <= `TMC_INSN_NOP;
                        else
                            ir_q <= prog_data; // [RULE17] [RULE3]
                        if (go_sleep)
                            core_asleep_q <= 1'b1;
                    end
                    default: begin
                        // Third phase: ALU settles
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Pad controls from software bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pullup_en_q <= 3'h0;
            port_pin_0_oe <= 1'b0;
            port_pin_1_oe <= 1'b0;
        end else begin
            // Reset-pin mode forces its pull-up on [RULE14] [RULE16]
            pullup_en_q <= {ctrl_q[`TMC_CT_PU3] | ctrl_q[`TMC_CT_XRST],
                            ctrl_q[`TMC_CT_PU1], ctrl_q[`TMC_CT_PU0]}; // [RULE15]
            port_pin_0_oe <= ctrl_q[`TMC_CT_DIR0]; // [RULE15]
            port_pin_1_oe <= ctrl_q[`TMC_CT_DIR1];
        end
    end

    // ==========================================================
    // APB slave: answer one cycle into the access phase
    assign apb_acc = psel & penable;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl_q <= `TMC_CT_RESET;
        end else if (apb_acc && !pready) begin
            // First access edge: present data and status
            pready <= 1'b1;
            pslverr <= 1'b0;
            case (paddr)
                `TMC_A_CTRL: prdata <= {23'h00_0000, ctrl_q};
                `TMC_A_CORE: prdata <= {4'h0, core_asleep_q, flags_q, w_q,
                                        {(16-PC_W){1'b0}}, pc_q};
                `TMC_A_PORT: prdata <= {25'h000_0000, port_pin_1_oe, port_pin_0_oe,
                                        pins_now[2], port_pin_1_out,
                                        port_pin_0_out, pins_now[1:0]};
                default: begin
                    // Unmapped: error, zero data
                    prdata <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end else begin
            // Completion edge: writes land only here
            if (apb_acc && pwrite && paddr == `TMC_A_CTRL)
                ctrl_q <= pwdata[8:0];
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule // tmc_core_top

// ===== dv/tmc_prog_mem.sv
// ==========
// Program store on the far side of the fetch bus
module tmc_prog_mem #(
    parameter SLOW = 0  // 1: answer one cycle late
) (
    input wire logic clk,
    input wire logic [8:0] addr,
    output logic [11:0] data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] mem [0:511];  // Whole words, own bus
    logic [11:0] late_q;  // Slow answer path
    // Late copy still lands well before the phase-four sample
    always @(posedge clk) begin
        late_q <= mem[addr];
    end
    assign data = SLOW ? late_q : mem[addr];  // One word per fetch
endmodule // tmc_prog_mem

// ===== dv/tmc_core_assertions.sv
`include "tmc_core_defines.vh"
// ==========
// Port-level checker
module tmc_core_chk #(
    parameter PC_W = 9
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [PC_W-1:0] prog_addr_q,
    input wire port_pin_0_oe,
    input wire port_pin_1_oe,
    input wire external_reset_pin,
    input wire [2:0] pullup_en_q,
    input wire core_asleep_q
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Write committed at this edge
    wire apb_commit = psel && penable && pready && pwrite;
    wire hit = paddr == `TMC_A_CTRL || paddr == `TMC_A_CORE || paddr == `TMC_A_PORT;
    // ==========
    // Register bus
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_access_two: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("access phase not two cycles");
    a_err_map: assert property (pready |-> pslverr == !hit)
        else $error("pslverr does not match address map");
    a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    // ==========
    // Fetch and pins
    a_fetch_stands: assert property ($changed(prog_addr_q)
        |=> ($stable(prog_addr_q) || !external_reset_pin) [*3])
        else $error("fetch address changed inside a cycle");
    a_sleep_still: assert property (core_asleep_q && $past(core_asleep_q)
        && external_reset_pin |-> $stable(prog_addr_q))
        else $error("fetch moved while asleep");
    // Pad register follows the control word one edge after the commit
    a_pullup_write: assert property ($changed(pullup_en_q) |-> $past(apb_commit, 2))
        else $error("pull-up changed without a write");
    a_oe_write: assert property ($changed(port_pin_0_oe) || $changed(port_pin_1_oe)
        |-> $past(apb_commit) || $past(apb_commit, 2))
        else $error("output enable changed without a write");
    c_sleep: cover property ($rose(core_asleep_q));
    c_refused: cover property (pready && pslverr);
    c_drive: cover property ($rose(port_pin_0_oe));
endmodule // tmc_core_chk
bind tmc_core_top tmc_core_chk #(.PC_W(PC_W)) chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr_q(prog_addr_q),
    .port_pin_0_oe(port_pin_0_oe), .port_pin_1_oe(port_pin_1_oe),
    .external_reset_pin(external_reset_pin), .pullup_en_q(pullup_en_q),
    .core_asleep_q(core_asleep_q));

// ===== dv/tmc_core_tb.sv
// ==========
// Core bench: APB master, fetch store, pad model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pad0 = 1'b1;  // Board level on pin 0
    logic pad3 = 1'b1;  // Input-only pin
    logic ext_rst = 1'b1;  // Reset pin idles high
    wire [31:0] prdata;
    wire pready, pslverr, out0, oe0, out1, oe1, asleep;
    wire [8:0] prog_addr_q;
    wire [11:0] prog_data;
    wire [2:0] pullup_en_q;
    wire pin0 = oe0 ? out0 : pad0;  // Core wins when driving
    wire pin1 = oe1 ? out1 : 1'b1;  // Board pull-up when released
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 51;
    logic [7:0] a, b;  // Random operands placed in the program
    logic [32:0] exp_q[$], msk_q[$], e, m;  // Notes: {pslverr, prdata}
    always #20 pclk = ~pclk;
    tmc_prog_mem #(.SLOW(1)) pm (.clk(pclk), .addr(prog_addr_q), .data(prog_data));
    tmc_core_top #(.PC_W(9), .DATA_WORDS(24)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr_q(prog_addr_q),
        .prog_data(prog_data), .port_pin_0_in(pin0), .port_pin_0_out(out0),
        .port_pin_0_oe(oe0), .port_pin_1_in(pin1), .port_pin_1_out(out1),
        .port_pin_1_oe(oe1), .port_pin_3_input(pad3), .external_reset_pin(ext_rst),
        .pullup_en_q(pullup_en_q), .core_asleep_q(asleep));
    // ==========
    // Closing report
    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, far above the expected run
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            $display("ERROR %0t timeout", $time);
            test_done();
        end
    end
    // Result watcher: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            checks++;
            if ((({pslverr, prdata} ^ e) & m) !== 33'h0) begin
                failures++;
                $display("ERROR %0t apb got %h want %h", $time, {pslverr, prdata}, e);
            end
        end
    end
    // ==========
    // Bus tasks; one idle edge first so nothing is driven twice at once
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
        input logic [32:0] ex, input logic [32:0] mk);
        @(posedge pclk);
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [2:0] got, input logic [2:0] ex);
        checks++;
        if (got !== ex) begin
            failures++;
            $display("ERROR %0t pull-up got %b want %b", $time, got, ex);
        end
    endtask
    // Expected CORE word at sleep point k of the test program
    function automatic logic [31:0] core_exp(input int k);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] w;
        logic z, dc, c;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        w = s[7:0];
        c = s[8];
        dc = h[4];
        if (k > 0) begin  // Subtract: flags are inverted borrows
            w = a - b;
            c = a >= b;
            dc = a[3:0] >= b[3:0];
        end
        z = w == 8'h00;
        if (k > 1) begin  // Rotate right through carry
            w = {c, a[7:1]};
            c = a[0];
        end
        if (k > 2) begin  // Mask to zero
            w = 8'h00;
            z = 1'b1;
        end
        return {4'h0, 1'b1, z, dc, c, w, 16'h0000};
    endfunction
    task automatic load();
        pm.mem[0] = {4'hc, a};
        pm.mem[2] = {4'hc, b};
        pm.mem[5] = {4'hc, b};
    endtask
    // ==========
    // Main sequence
    initial begin
        for (int i = 0; i < 512; i++) pm.mem[i] = 12'h000;
        pm.mem[1] = 12'h028;
        pm.mem[3] = 12'h1c8;
        pm.mem[4] = 12'h003;
        pm.mem[6] = 12'h088;
        pm.mem[7] = 12'h003;
        pm.mem[8] = 12'h308;
        pm.mem[9] = 12'h003;
        pm.mem[10] = 12'he00;
        pm.mem[11] = 12'h003;
        pm.mem[12] = 12'ha00;
        {a, b} = 16'($random(seed));
        load();
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 33'h0, 33'h1ffffffff);
        apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0}, 33'h1ffffffff);
        apb(1'b1, 12'h000, 32'h07e, 33'h0, {1'b1, 32'h0});
        // Pad register lands one edge after the commit; look once it has settled
        repeat (2) @(posedge pclk);
        chk(pullup_en_q, 3'b111);
        // Four sleep points per pass, new random operands each pass
        for (int t = 0; t < 4; t++) begin
            for (int k = 0; k < 4; k++) begin
                while (asleep !== 1'b1) @(posedge pclk);
                apb(1'b0, 12'h004, 32'h0, {1'b0, core_exp(k)}, 33'h10fff0000);
                if (k == 3) begin
                    {a, b} = 16'($random(seed));
                    load();
                end
                pad0 <= ~pad0;
                while (asleep !== 1'b0) @(posedge pclk);
            end
        end
        // Reset-pin mode without wakes, so driving pin 0 cannot wake it
        while (asleep !== 1'b1) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h181, 33'h0, {1'b1, 32'h0});
        repeat (2) @(posedge pclk);
        chk(pullup_en_q, 3'b100);
        apb(1'b0, 12'h008, 32'h0, 33'h70, 33'h10000007f);
        ext_rst <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0, {1'b0, core_exp(0) & 32'h07ff0000}, 33'h10fffffff);
        ext_rst <= 1'b1;
        @(posedge pclk);
        while (asleep !== 1'b1) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0, {1'b0, core_exp(0)}, 33'h10fff0000);
        test_done();
    end
endmodule // tb
